//--- hw/swm_cfg.svh
/*
  Constants for the write-data capture path: organisation defaults, lane
  geometry and reset values. Included by the design files by bare name.
*/
`ifndef SWM_CFG_SVH
`define SWM_CFG_SVH

// ---------------------------------------------------------------------
// Organisation defaults
// ---------------------------------------------------------------------
`define SWM_DATA_W      36
`define SWM_ADDR_W      18

// ---------------------------------------------------------------------
// Lane geometry
// ---------------------------------------------------------------------
`define SWM_BYTE_LANE_W 9
`define SWM_NIB_LANE_W  4
`define SWM_BYTE_LANES  4
`define SWM_NIB_LANES   2
`define SWM_NIB_ORG_W   8

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define SWM_PIN_IDLE    1'b1
`define SWM_TAIL_FREE   1'b1

`endif

//--- hw/swm_pkg.sv
/*
  Types shared by the write-data capture path.
  Assumes swm_cfg.svh is on the include path.
*/
package swm_pkg;

  // -------------------------------------------------------------------
  // Burst capture states
  // -------------------------------------------------------------------
  typedef enum logic
  {
    SWM_IDLE,
    SWM_WAIT_SECOND
  } swm_state_t;

endpackage

//--- hw/swm_buf2.sv
/*
  Two-entry buffer with valid/ready on both sides; head and flags are
  flip-flops so the outputs need no logic after them.
  Assumes one clock, asynchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ps
`include "swm_cfg.svh"

module swm_buf2
  import swm_pkg::*;
#(
  parameter int W = 8
)
(
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  logic         head_v_r;
  logic         tail_free_r;
  logic [W-1:0] head_r;
  logic [W-1:0] tail_r;
  wire          push_w = in_valid_i & tail_free_r;
  wire          pop_w  = head_v_r & out_ready_i;

  assign in_ready_o  = tail_free_r;
  assign out_valid_o = head_v_r;
  assign out_data_o  = head_r;

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      head_v_r    <= 1'b0;
      tail_free_r <= `SWM_TAIL_FREE;
    end
    else if (ce_i)
    begin
      if (pop_w)
      begin
        head_v_r    <= !tail_free_r | push_w;
        tail_free_r <= 1'b1;
      end
      else if (push_w && head_v_r)
        tail_free_r <= 1'b0;
      else if (push_w)
        head_v_r <= 1'b1;
    end
  end

  // Data needs no reset; valid flags guard it
  always_ff @(posedge mclk_i)
  begin
    if (ce_i)
    begin
      if (pop_w)
        head_r <= tail_free_r ? in_data_i : tail_r;
      else if (push_w && !head_v_r)
        head_r <= in_data_i;
      if (push_w && head_v_r && !pop_w)
        tail_r <= in_data_i;
    end
  end

endmodule

//--- hw/swm_write_capture.sv
/*
  Write-data capture for a burst-of-two SRAM write port: samples the data
  bus and active-low lane enables on both primary clock halves and hands a
  masked wide-word write to the array through a two-entry buffer.
  Assumes the primary clock pair runs well below a quarter of mclk_i, so
  that every pin, once synchronised, is stable around each sampled edge.
*/
`timescale 1ns/1ps
`include "swm_cfg.svh"

module swm_write_capture
  import swm_pkg::*;
#(
  parameter int DW = `SWM_DATA_W,
  parameter int AW = `SWM_ADDR_W
)
(
  // Clock, reset, enable
  input  wire logic                          mclk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          ce_i,
  // Write port pins
  input  wire logic                          kclk_i,
  input  wire logic                          kclk_n_i,
  input  wire logic                          write_sel_n_i,
  input  wire logic [AW-1:0]                 shared_addr_bus_i,
  input  wire logic [DW-1:0]                 wdata_i,
  input  wire logic [`SWM_BYTE_LANES-1:0]    lane_write_enable_n_i,
  input  wire logic [`SWM_NIB_LANES-1:0]     nibble_lane_enable_n_i,
  // Wide-word write strobe toward the array
  output logic                               wr_valid_o,
  input  wire logic                          wr_ready_i,
  output logic [AW-1:0]                      wr_addr_o,
  output logic [2*DW-1:0]                    wr_data_o,
  output logic [2*DW-1:0]                    wr_mask_o,
  // Buffer status
  output logic                               fill_ready_o,
  output logic                               drop_o
);

  localparam int LW = (DW == `SWM_NIB_ORG_W) ? `SWM_NIB_LANE_W : `SWM_BYTE_LANE_W;
  localparam int BW = AW + 4*DW;

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  // Active-low lane enables to an active-high per-bit write mask
  function automatic logic [DW-1:0] lane_mask
  (
    input logic [`SWM_BYTE_LANES-1:0] len_n,
    input logic [`SWM_NIB_LANES-1:0]  nib_n
  );
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < DW; i++)
    begin
      // Modulo keeps the unused branch's index in range at every width
      if (DW == `SWM_NIB_ORG_W)
        m[i] = ~nib_n[(i / `SWM_NIB_LANE_W) % `SWM_NIB_LANES];
      else
        m[i] = ~len_n[(i / `SWM_BYTE_LANE_W) % `SWM_BYTE_LANES];
    end
    return m;
  endfunction

  // True when every lane of the mask is all on or all off
  function automatic logic lanes_uniform(input logic [DW-1:0] m);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < DW; i++)
      if (m[i] != m[(i / LW) * LW])
        ok = 1'b0;
    return ok;
  endfunction

  // -------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------
  // Buses pass the same two stages as the clocks, so samples stay aligned
  logic                       k_s1, k_s2, k_d;
  logic                       kn_s1, kn_s2, kn_d;
  logic                       wsel_s1, wsel_s2;
  logic [AW-1:0]              addr_s1, addr_s2;
  logic [DW-1:0]              d_s1, d_s2;
  logic [`SWM_BYTE_LANES-1:0] len_s1, len_s2;
  logic [`SWM_NIB_LANES-1:0]  nib_s1, nib_s2;

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      {k_s1, k_s2, k_d}    <= '0;
      {kn_s1, kn_s2, kn_d} <= '0;
      wsel_s1              <= `SWM_PIN_IDLE;
      wsel_s2              <= `SWM_PIN_IDLE;
    end
    else if (ce_i)
    begin
      {k_s1, k_s2, k_d}    <= {kclk_i, k_s1, k_s2};
      {kn_s1, kn_s2, kn_d} <= {kclk_n_i, kn_s1, kn_s2};
      wsel_s1              <= write_sel_n_i;
      wsel_s2              <= wsel_s1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (ce_i)
    begin
      {addr_s1, addr_s2} <= {shared_addr_bus_i, addr_s1};
      {d_s1, d_s2}       <= {wdata_i, d_s1};
      {len_s1, len_s2}   <= {lane_write_enable_n_i, len_s1};
      {nib_s1, nib_s2}   <= {nibble_lane_enable_n_i, nib_s1};
    end
  end

  // -------------------------------------------------------------------
  // Edge decode and masking
  // -------------------------------------------------------------------
  wire            k_rise_w  = k_s2 & ~k_d;
  wire            kn_rise_w = kn_s2 & ~kn_d;
  wire [DW-1:0]   mask_w    = lane_mask(len_s2, nib_s2);
  // Zeroing disabled lanes keeps stray pin data out of the array
  wire [DW-1:0]   dmask_w   = d_s2 & mask_w;

  // -------------------------------------------------------------------
  // Burst capture
  // -------------------------------------------------------------------
  swm_state_t     state_r, state_nxt;
  logic [DW-1:0]  word0_r, mask0_r;
  logic           burst_v_r, drop_r;
  logic [BW-1:0]  burst_r;
  logic           buf_ready_w;

  wire start_w  = (state_r == SWM_IDLE) && k_rise_w && !wsel_s2;
  wire finish_w = (state_r == SWM_WAIT_SECOND) && kn_rise_w;
  wire any_w    = |{mask0_r, mask_w};

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SWM_IDLE:        if (start_w)  state_nxt = SWM_WAIT_SECOND;
      SWM_WAIT_SECOND: if (finish_w) state_nxt = SWM_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r   <= SWM_IDLE;
      burst_v_r <= 1'b0;
      drop_r    <= 1'b0;
    end
    else if (ce_i)
    begin
      state_r   <= state_nxt;
      burst_v_r <= finish_w && any_w;
      drop_r    <= burst_v_r && !buf_ready_w;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (ce_i)
    begin
      if (start_w)
      begin
        word0_r <= dmask_w;
        mask0_r <= mask_w;
      end
      if (finish_w)
        burst_r <= {addr_s2, mask_w, mask0_r, dmask_w, word0_r};
    end
  end

  assign drop_o = drop_r;

  // -------------------------------------------------------------------
  // Output buffer
  // -------------------------------------------------------------------
  logic [BW-1:0] head_w;

  swm_buf2 #(
    .W (BW)
  ) u_buf (
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .in_valid_i  (burst_v_r),
    .in_ready_o  (buf_ready_w),
    .in_data_i   (burst_r),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (head_w)
  );

  assign fill_ready_o = buf_ready_w;
  assign {wr_addr_o, wr_mask_o, wr_data_o} = head_w;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  sequence seq_first_half;
    ce_i && start_w;
  endsequence

  sequence seq_second_half;
    ce_i && finish_w;
  endsequence

  chk_org_width: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    DW == 8 || DW == 9 || DW == 18 || DW == 36)
    else $error("Unsupported data width");

  chk_first_word: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    seq_first_half |=> state_r == SWM_WAIT_SECOND && word0_r == $past(d_s2 & mask_w))
    else $error("First word not captured at true clock rise");

  chk_write_deselect: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && state_r == SWM_IDLE && k_rise_w && wsel_s2 |=> state_r == SWM_IDLE)
    else $error("Write started with select high");

  chk_burst_pair: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (seq_second_half and any_w)
    |=> burst_v_r && burst_r[BW-1 -: AW] == $past(addr_s2)
        && burst_r[2*DW-1:DW] == $past(dmask_w))
    else $error("Second word and address not pushed together");

  chk_mask_active_low: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    seq_first_half |=> mask0_r[0] == !$past(DW == 8 ? nib_s2[0] : len_s2[0]))
    else $error("Lane enable polarity wrong");

  chk_ignored_lane: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_valid_o |-> (wr_data_o & ~wr_mask_o) == '0)
    else $error("Disabled lane carries data");

  chk_lane_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    DW != 8 |-> (&mask_w[LW-1:0]) || !(|mask_w[LW-1:0]))
    else $error("Lane zero does not cover bits 8 to 0");

  chk_wide_lanes: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    DW >= 18 |-> lanes_uniform(mask_w))
    else $error("Nine-bit lanes split");

  chk_nibble_lanes: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    DW == 8 |-> mask_w[3:0] == {4{~nib_s2[0]}} && mask_w[DW-1:DW-4] == {4{~nib_s2[1]}})
    else $error("Nibble enables misrouted");

  chk_no_empty_write: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (seq_second_half and !any_w) |=> !burst_v_r)
    else $error("Fully masked burst was written");

  chk_hold_on_stall: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ce_i && wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(head_w))
    else $error("Stalled write changed");

endmodule

//--- test/swm_ctrl_model.sv
/*
  Controller model that drives the write port pins of the capture block.
  Assumes mclk_i from the bench; pins change only on its falling edge.
*/
`timescale 1ns/1ps

module swm_ctrl_model
(
  // Clock
  input  wire logic        mclk_i,
  // Write port pins
  output logic             kclk_o,
  output logic             kclk_n_o,
  output logic             sel_n_o,
  output logic [17:0]      addr_o,
  output logic [35:0]      data_o,
  output logic [3:0]       lane_n_o,
  output logic [1:0]       nib_n_o
);
  initial
  begin
    kclk_o = 1'b0;
    kclk_n_o = 1'b0;
    sel_n_o = 1'b1;
    addr_o = 18'h00000;
    data_o = 36'h000000000;
    lane_n_o = 4'hf;
    nib_n_o = 2'h3;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // Slow K: pins settle 4 cycles before each rising edge and hold 8 after it
  task automatic burst(input logic s, input logic [17:0] a, input logic [35:0] d0,
                       input logic [35:0] d1, input logic [3:0] l0, input logic [3:0] l1);
    sel_n_o = s;
    data_o = d0;
    lane_n_o = l0;
    nib_n_o = l0[1:0];
    hold(4);
    kclk_o = 1'b1;
    hold(8);
    data_o = d1;
    lane_n_o = l1;
    nib_n_o = l1[1:0];
    addr_o = a;
    kclk_o = 1'b0;
    hold(4);
    kclk_n_o = 1'b1;
    hold(8);
    // Released data, address and lane pins show the inverse, never the last value
    kclk_n_o = 1'b0;
    sel_n_o = 1'b1;
    data_o = ~d1;
    addr_o = ~a;
    lane_n_o = ~l1;
    nib_n_o = ~l1[1:0];
    hold(4);
  endtask
endmodule

//--- test/testbench.sv
/*
  Self-checking bench for the write capture block at 36-bit width, with
  an 8-bit instance on the same pins for the nibble enables.
  Assumes the controller model drives all pins; the bench owns wr_ready_i.
*/
`timescale 1ns/1ps

module testbench;
  logic        mclk_i;
  logic        rstn_i;
  logic        wr_ready_i;
  wire         kclk;
  wire         kclk_n;
  wire         sel_n;
  wire [17:0]  addr;
  wire [35:0]  data;
  wire [3:0]   lane_n;
  wire [1:0]   nib_n;
  wire         wr_valid_o;
  wire [17:0]  wr_addr_o;
  wire [71:0]  wr_data_o;
  wire [71:0]  wr_mask_o;
  wire         fill_ready_o;
  wire         drop_o;
  int          mismatches;
  int          comparisons;
  int          drops;
  logic        ce;
  logic        rdy8;
  wire         wr_valid8;
  wire [17:0]  wr_addr8;
  wire [15:0]  wr_data8;
  wire [15:0]  wr_mask8;

  swm_ctrl_model m (.mclk_i(mclk_i), .kclk_o(kclk), .kclk_n_o(kclk_n), .sel_n_o(sel_n),
    .addr_o(addr), .data_o(data), .lane_n_o(lane_n), .nib_n_o(nib_n));

  swm_write_capture #(.DW(8), .AW(18)) uut_nib (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce),
    .kclk_i(kclk), .kclk_n_i(kclk_n), .write_sel_n_i(sel_n), .shared_addr_bus_i(addr),
    .wdata_i(data[7:0]), .lane_write_enable_n_i(lane_n), .nibble_lane_enable_n_i(nib_n),
    .wr_valid_o(wr_valid8), .wr_ready_i(rdy8), .wr_addr_o(wr_addr8), .wr_data_o(wr_data8),
    .wr_mask_o(wr_mask8), .fill_ready_o(), .drop_o());

  swm_write_capture #(.DW(36), .AW(18)) uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce),
    .kclk_i(kclk), .kclk_n_i(kclk_n), .write_sel_n_i(sel_n), .shared_addr_bus_i(addr),
    .wdata_i(data), .lane_write_enable_n_i(lane_n), .nibble_lane_enable_n_i(nib_n),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .wr_mask_o(wr_mask_o), .fill_ready_o(fill_ready_o),
    .drop_o(drop_o));

  always #4 mclk_i = ~mclk_i;

  // Counted mid-cycle, away from the edge that launches the pulse
  always @(negedge mclk_i)
    if (drop_o === 1'b1)
      drops <= drops + 1;

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One nine-bit lane per active-low enable
  function automatic logic [35:0] lmask(input logic [3:0] l);
    for (int n = 0; n < 4; n++)
      lmask[9*n +: 9] = {9{~l[n]}};
  endfunction

  // Waits bounded for the head word, judges it, then takes it in one cycle
  task automatic expect_word(input logic [17:0] a, input logic [35:0] d0,
                             input logic [35:0] d1, input logic [3:0] l0, input logic [3:0] l1);
    logic [71:0] mk;
    int          i;
    mk = {lmask(l1), lmask(l0)};
    i = 0;
    while (wr_valid_o !== 1'b1 && i < 40)
    begin
      @(negedge mclk_i);
      i++;
    end
    if (i == 40)
    begin
      mismatches++;
      $display("MISMATCH wr_valid_o expected 1 seen %b", wr_valid_o);
    end
    else
    begin
      chk("wr_addr_o", {54'h0, a}, {54'h0, wr_addr_o});
      chk("wr_mask_o", mk, wr_mask_o);
      chk("wr_data_o", {d1, d0} & mk, wr_data_o);
      wr_ready_i = 1'b1;
      @(negedge mclk_i);
      wr_ready_i = 1'b0;
      // One quiet edge so a following call never re-raises ready at once
      @(negedge mclk_i);
    end
  endtask

  task automatic t_full();
    m.burst(1'b0, 18'h2a5a5, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
    expect_word(18'h2a5a5, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
    $display("test full done");
  endtask

  task automatic t_lanes();
    m.burst(1'b0, 18'h00001, 36'hfffffffff, 36'h5a5a5a5a5, 4'ha, 4'h5);
    expect_word(18'h00001, 36'hfffffffff, 36'h5a5a5a5a5, 4'ha, 4'h5);
    $display("test lanes done");
  endtask

  task automatic t_quiet();
    m.burst(1'b0, 18'h3ffff, 36'h0f0f0f0f0, 36'hfffffffff, 4'h0, 4'hf);
    expect_word(18'h3ffff, 36'h0f0f0f0f0, 36'hfffffffff, 4'h0, 4'hf);
    m.burst(1'b0, 18'h00002, 36'h111111111, 36'h222222222, 4'hf, 4'hf);
    chk("wr_valid_o", 72'h0, {71'h0, wr_valid_o});
    m.burst(1'b1, 18'h00003, 36'h333333333, 36'h444444444, 4'h0, 4'h0);
    chk("wr_valid_o", 72'h0, {71'h0, wr_valid_o});
    $display("test quiet done");
  endtask

  task automatic t_overflow();
    int d;
    d = drops;
    m.burst(1'b0, 18'h00010, 36'h0000000aa, 36'h0000000bb, 4'h0, 4'h0);
    m.burst(1'b0, 18'h00020, 36'h0000000cc, 36'h0000000dd, 4'h0, 4'h0);
    chk("fill_ready_o", 72'h0, {71'h0, fill_ready_o});
    m.burst(1'b0, 18'h00030, 36'h0000000ee, 36'h0000000ff, 4'h0, 4'h0);
    chk("drop_o pulses", 72'h1, 72'(drops - d));
    // Clock enable low must hold the full buffer even with ready high
    ce = 1'b0;
    wr_ready_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk("wr_valid_o frozen", 72'h1, {71'h0, wr_valid_o});
    chk("fill_ready_o frozen", 72'h0, {71'h0, fill_ready_o});
    ce = 1'b1;
    wr_ready_i = 1'b0;
    @(negedge mclk_i);
    expect_word(18'h00010, 36'h0000000aa, 36'h0000000bb, 4'h0, 4'h0);
    expect_word(18'h00020, 36'h0000000cc, 36'h0000000dd, 4'h0, 4'h0);
    @(negedge mclk_i);
    chk("wr_valid_o", 72'h0, {71'h0, wr_valid_o});
    $display("test overflow done");
  endtask

  task automatic t_nibble();
    rdy8 = 1'b0;
    m.burst(1'b0, 18'h00155, 36'h0000000a5, 36'h00000003c, 4'h2, 4'h1);
    chk("nibble wr_valid_o", 72'h1, {71'h0, wr_valid8});
    chk("nibble wr_addr_o", 72'h155, {54'h0, wr_addr8});
    chk("nibble wr_mask_o", 72'hf00f, {56'h0, wr_mask8});
    chk("nibble wr_data_o", 72'h3005, {56'h0, wr_data8});
    rdy8 = 1'b1;
    @(negedge mclk_i);
    chk("nibble wr_valid_o", 72'h0, {71'h0, wr_valid8});
    expect_word(18'h00155, 36'h0000000a5, 36'h00000003c, 4'h2, 4'h1);
    $display("test nibble done");
  endtask

  initial
  begin
    mclk_i = 1'b0;
    rstn_i = 1'b0;
    wr_ready_i = 1'b0;
    ce = 1'b1;
    rdy8 = 1'b1;
    mismatches = 0;
    comparisons = 0;
    drops = 0;
    repeat (8) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    t_full();
    t_lanes();
    t_quiet();
    t_overflow();
    t_nibble();
    tally_and_finish();
  end
endmodule
